/* sim/lpdpmc_bench.sv */
// Bench: dimming, gain sequencing and protection scenarios
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; \
    $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end
module lpdpmc_bench;
    localparam int unsigned SHDN  = 40;
    localparam int unsigned RETRY = 200;
    logic       clk;
    logic       rst;
    logic       main_pin;
    logic       sub_pin;
    logic [5:0] sink_low;
    logic [5:0] over_limit;
    logic       dropout;
    logic       below;
    logic       short_in;
    logic       hot;
    logic       active;
    logic       short_mode;
    logic [1:0] gain;
    logic [5:0] sink_en;
    logic [6:0] main_pct;
    logic [6:0] sub_pct;
    logic [3:0] main_lvl;
    logic [3:0] sub_lvl;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    lpdpmc_host host (.i_clk_sys(clk), .o_main(main_pin), .o_sub(sub_pin));
    lpdpmc_top #(.SHDN_CYC(SHDN), .SOFT_CYC(8), .GAIN_CYC(20), .RETRY_CYC(RETRY)) dut (
        .i_clk_sys(clk), .i_rst(rst), .i_main_group_pulse_input(main_pin),
        .i_sub_group_pulse_input(sub_pin), .i_sink_low(sink_low), .i_dropout(dropout),
        .i_pump_below_supply(below), .i_pump_short(short_in), .i_sink_over_limit(over_limit),
        .i_over_temp(hot), .o_active(active), .o_short_mode(short_mode), .o_gain(gain),
        .o_sink_en(sink_en), .o_main_pct(main_pct), .o_sub_pct(sub_pct),
        .o_main_level(main_lvl), .o_sub_level(sub_lvl));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function automatic logic [6:0] exp_pct(input int l);
        return (l == 10) ? 7'h05 : 7'h64 - 7'h0A * 7'(l);
    endfunction
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_gain(input logic [1:0] g, input int max);
        int i;
        i = 0;
        while (gain !== g && i < max) begin
            step(1);
            i++;
        end
        `CHK(gain, g)
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_main_dim;
        host.start(0);
        `CHK(active, 1'b1)
        `CHK({main_pct, sink_en[3:0]}, {7'h64, 4'hF})
        for (int k = 1; k <= 11; k++) begin
            host.pulse(0, 1);
            `CHK(main_lvl, 4'(k % 11))
            `CHK(main_pct, exp_pct(k % 11))
        end
    endtask
    task automatic t_absolute;
        host.pulse(0, 3);
        host.long_low(0);
        `CHK(sink_en[3:0], 4'h0)
        `CHK(active, 1'b0)
        host.first_high(0);
        `CHK({main_lvl, main_pct}, {4'h0, 7'h64})
        host.pulse(0, 7);
        `CHK(main_pct, 7'h1E)
    endtask
    task automatic t_sub_dim;
        host.start(1);
        `CHK({sub_pct, sink_en}, {7'h64, 6'h3F})
        for (int k = 1; k <= 11; k++) begin
            host.pulse(1, 1);
            `CHK({sub_lvl, sub_pct}, {4'(k % 11), exp_pct(k % 11)})
        end
        `CHK(main_pct, 7'h1E)
    endtask
    task automatic t_gain;
        sink_low = 6'h01;
        dropout = 1'b1;
        step(4);
        `CHK(gain, 2'h1)
        step(12);
        `CHK(gain, 2'h1)
        wait_gain(2'h2, 20);
        dropout = 1'b0;
        host.long_low(0);
        `CHK(gain, 2'h1)
        host.first_high(0);
        dropout = 1'b1;
        wait_gain(2'h2, 30);
        wait_gain(2'h1, RETRY + 10);
        wait_gain(2'h2, 30);
        dropout = 1'b0;
        sink_low = 6'h00;
        below = 1'b1;
        wait_gain(2'h0, 2 * RETRY + 20);
        step(20);
        `CHK(gain, 2'h0)
        sink_low = 6'h10;
        wait_gain(2'h1, 6);
        sink_low = 6'h00;
        below = 1'b0;
    endtask
    task automatic t_protect;
        over_limit = 6'h02;
        step(4);
        `CHK(sink_en, 6'h3D)
        over_limit = 6'h00;
        step(4);
        `CHK(sink_en, 6'h3F)
        short_in = 1'b1;
        step(4);
        `CHK({short_mode, gain}, {1'b1, 2'h0})
        short_in = 1'b0;
        step(3);
        `CHK(short_mode, 1'b0)
        hot = 1'b1;
        step(3);
        `CHK({active, sink_en}, {1'b0, 6'h00})
        hot = 1'b0;
        host.start(0);
        `CHK(active, 1'b1)
        host.start(1);
        `CHK(sink_en, 6'h3F)
        host.long_low(1);
        `CHK({active, sink_en[5:4]}, {1'b1, 2'h0})
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        rst = 1'b1;
        {sink_low, over_limit, dropout, below, short_in, hot} = '0;
        step(8);
        rst = 1'b0;
        t_main_dim();
        t_absolute();
        t_sub_dim();
        t_gain();
        t_protect();
        tally_and_finish();
    end
endmodule

/* sim/lpdpmc_host.sv */
// Host model: drives the two group pulse pins
`timescale 1ns/100ps
module lpdpmc_host #(
    parameter int unsigned SHDN_CYC = 40,
    parameter int unsigned SOFT_CYC = 8
) (
    input  wire logic i_clk_sys,
    output logic      o_main,
    output logic      o_sub
);
    initial begin
        o_main = 1'b0;
        o_sub  = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic set_pin(input bit sub, input logic v);
        @(posedge i_clk_sys);
        #1;
        if (sub) o_sub = v;
        else o_main = v;
    endtask
    task automatic long_low(input bit sub);
        set_pin(sub, 1'b0);
        hold(SHDN_CYC + 10);
    endtask
    task automatic first_high(input bit sub);
        set_pin(sub, 1'b1);
        hold(SOFT_CYC + 8);
    endtask
    task automatic start(input bit sub);
        long_low(sub);
        first_high(sub);
    endtask
    // Short lows, back to back, keep a burst well inside a few ms
    task automatic pulse(input bit sub, input int n);
        repeat (n) begin
            set_pin(sub, 1'b0);
            hold(2);
            set_pin(sub, 1'b1);
            hold(5);
        end
    endtask
endmodule

/* sim/lpdpmc_monitor.sv */
// Checker: gain sequencing, shutdown and dimming relations at the top ports
`timescale 1ns/100ps
module lpdpmc_monitor #(
    parameter int unsigned SHDN_CYC  = 40,
    parameter int unsigned GAIN_CYC  = 20,
    parameter int unsigned RETRY_CYC = 200,
    parameter int unsigned SINKS     = 6
) (
    input wire logic             i_clk_sys,
    input wire logic             i_rst,
    input wire logic             i_main_group_pulse_input,
    input wire logic             i_sub_group_pulse_input,
    input wire logic             i_pump_short,
    input wire logic             i_over_temp,
    input wire logic [SINKS-1:0] i_sink_over_limit,
    input wire logic             o_active,
    input wire logic             o_short_mode,
    input wire logic [1:0]       o_gain,
    input wire logic [SINKS-1:0] o_sink_en,
    input wire logic [6:0]       o_main_pct,
    input wire logic [3:0]       o_main_level,
    input wire logic [3:0]       o_sub_level
);
    int unsigned both_lo;
    int unsigned main_lo;
    int unsigned in15;
    int unsigned in2;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    function automatic logic [6:0] pct_of(input logic [3:0] l);
        return (l == 4'hA) ? 7'h05 : 7'h64 - 7'h0A * 7'(l);
    endfunction
    // ----
    // Cycle counters
    // ----
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            both_lo <= 0;
            main_lo <= 0;
            in15    <= 0;
            in2     <= 0;
        end else begin
            both_lo <= (i_main_group_pulse_input | i_sub_group_pulse_input) ? 0 : both_lo + 1;
            main_lo <= i_main_group_pulse_input ? 0 : main_lo + 1;
            in15    <= (o_gain == 2'h1) ? in15 + 1 : 0;
            in2     <= (o_gain == 2'h2) ? in2 + 1 : 0;
        end
    end
    // ----
    // Assertions
    // ----
    gain_via_15x_a: assert property ($past(o_gain) == 2'h0 |-> o_gain != 2'h2)
        else $error("gain went from 1x straight to 2x");
    hold_15x_a: assert property (
        o_gain == 2'h2 && $past(o_gain) == 2'h1 |-> in15 + 2 >= GAIN_CYC)
        else $error("2x entered before the 1.5x hold ran out");
    retry_2x_a: assert property (in2 <= RETRY_CYC + 3)
        else $error("2x held past the retry period");
    short_follow_a: assert property (i_pump_short && !i_over_temp |=> o_short_mode)
        else $error("short mode not entered");
    short_gain_a: assert property (i_pump_short [*3] |-> o_gain == 2'h0)
        else $error("gain not 1x while output shorted");
    over_limit_a: assert property ($stable(i_sink_over_limit) [*3] |->
        (o_sink_en & i_sink_over_limit) == '0)
        else $error("sink above limit still enabled");
    main_off_a: assert property (main_lo >= SHDN_CYC + 5 |-> o_sink_en[3:0] == 4'h0)
        else $error("main sinks on after long low");
    shut_all_a: assert property (both_lo >= SHDN_CYC + 4 |-> !o_active)
        else $error("device active with both inputs long low");
    hot_off_a: assert property (i_over_temp |=> !o_active)
        else $error("device active while over temperature");
    level_range_a: assert property (o_main_level <= 4'hA && o_sub_level <= 4'hA)
        else $error("level index out of range");
    pct_map_a: assert property (o_main_pct != 7'h00 && $stable(o_main_level) |->
        o_main_pct == pct_of(o_main_level))
        else $error("main percent does not match level");
    cover property (o_gain == 2'h2);
    cover property (o_short_mode);
    cover property (o_main_level == 4'hA);
endmodule

bind lpdpmc_top lpdpmc_monitor #(.SHDN_CYC(SHDN_CYC), .GAIN_CYC(GAIN_CYC),
    .RETRY_CYC(RETRY_CYC), .SINKS(SINKS)) u_monitor (.i_clk_sys, .i_rst,
    .i_main_group_pulse_input, .i_sub_group_pulse_input, .i_pump_short, .i_over_temp,
    .i_sink_over_limit, .o_active, .o_short_mode, .o_gain, .o_sink_en, .o_main_pct,
    .o_main_level, .o_sub_level);

/* verilog/lpdpmc_group.sv */
// One pulse dimming group: long-low detect, soft start and level index
`timescale 1ns/100ps
module lpdpmc_group #(
    parameter int unsigned SHDN_CYC = lpdpmc_pkg::SHDN_CYC,
    parameter int unsigned SOFT_CYC = lpdpmc_pkg::SOFT_CYC
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_pulse,
    input  wire logic       i_enable_ok,
    output logic            o_on,
    output logic            o_long_low,
    output logic            o_step,
    output logic [3:0]      o_level,
    output logic [6:0]      o_pct
);
    lpdpmc_pkg::lpdpmc_grp_e state;
    logic                    pin_d;
    logic [31:0]             low_cnt;
    logic [31:0]             soft_cnt;
    logic                    rise;
    logic                    fall;

    assign rise = i_pulse & ~pin_d;
    assign fall = ~i_pulse & pin_d;

    // Level index to percent: 100 down by 10 per step, last step is 5
    function automatic logic [6:0] level_pct(input logic [3:0] lvl);
        if (lvl == lpdpmc_pkg::LEVEL_LAST) begin
            return lpdpmc_pkg::PCT_MIN;
        end
        return 7'(lpdpmc_pkg::PCT_FULL - 7'(lvl * lpdpmc_pkg::PCT_STEP));
    endfunction

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pin_d <= 1'b0;
        end else begin
            pin_d <= i_pulse;
        end
    end

    // ---------------------------------------------------------------
    // Long-low timer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            low_cnt    <= '0;
            o_long_low <= 1'b1;
        end else if (i_pulse) begin
            low_cnt    <= '0;
            o_long_low <= 1'b0;
        end else if (low_cnt < SHDN_CYC - 1) begin
            low_cnt <= low_cnt + 32'h1;
        end else begin
            o_long_low <= 1'b1;                     // see (R12)
        end
    end

    // ---------------------------------------------------------------
    // Group state and level
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state    <= lpdpmc_pkg::LPDPMC_OFF;
            soft_cnt <= '0;
            o_level  <= lpdpmc_pkg::LEVEL_FULL;
            o_on     <= 1'b0;
            o_step   <= 1'b0;
        end else begin
            o_step <= 1'b0;
            unique case (state)
                lpdpmc_pkg::LPDPMC_OFF: begin
                    o_on <= 1'b0;
                    if (rise && i_enable_ok) begin
                        state    <= lpdpmc_pkg::LPDPMC_SOFT;     // see (R07) see (R10)
                        soft_cnt <= '0;
                        o_level  <= lpdpmc_pkg::LEVEL_FULL;      // see (R12) see (R22)
                    end
                end
                lpdpmc_pkg::LPDPMC_SOFT: begin
                    if (o_long_low || !i_enable_ok) begin
                        state <= lpdpmc_pkg::LPDPMC_OFF;
                    end else if (soft_cnt >= SOFT_CYC - 1) begin
                        state <= lpdpmc_pkg::LPDPMC_ON;
                        o_on  <= 1'b1;
                    end else begin
                        soft_cnt <= soft_cnt + 32'h1;
                    end
                    if (fall) begin
                        o_step <= 1'b1;
                    end
                end
                lpdpmc_pkg::LPDPMC_ON: begin
                    if (o_long_low || !i_enable_ok) begin
                        state <= lpdpmc_pkg::LPDPMC_OFF;         // see (R12)
                        o_on  <= 1'b0;
                    end else if (rise) begin
                        o_step <= 1'b1;
                        if (o_level == lpdpmc_pkg::LEVEL_LAST) begin
                            o_level <= lpdpmc_pkg::LEVEL_FULL;   // see (R08) see (R11) see (R22)
                        end else begin
                            o_level <= o_level + lpdpmc_pkg::LEVEL_ONE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pct <= lpdpmc_pkg::PCT_ZERO;
        end else if (state == lpdpmc_pkg::LPDPMC_OFF) begin
            o_pct <= lpdpmc_pkg::PCT_ZERO;
        end else begin
            o_pct <= level_pct(o_level);                 // see (R06) see (R09)
        end
    end
endmodule

/* verilog/lpdpmc_pkg.sv */
// Package: constants for the LED pulse dimming and pump mode controller
package lpdpmc_pkg;
    localparam int unsigned CLK_HZ          = 250_000_000;
    localparam int unsigned NS_PER_S        = 1_000_000_000;
    // Times in their own units
    localparam int unsigned SHDN_HOLD_US    = 500;     // 0.5 ms long-low time
    localparam int unsigned GAIN_HOLD_US    = 1000;    // 1 ms in 1.5x before 2x
    localparam int unsigned RETRY_MS        = 130;     // periodic gain retry
    localparam int unsigned SOFT_START_US   = 50;      // ramp before full current
    localparam int unsigned US_PER_S        = 1_000_000;
    localparam int unsigned MS_PER_S        = 1_000;
    // Derived cycle counts (all above 4096, used as top parameter defaults)
    localparam int unsigned SHDN_CYC   = SHDN_HOLD_US * (CLK_HZ / US_PER_S);
    localparam int unsigned GAIN_CYC   = GAIN_HOLD_US * (CLK_HZ / US_PER_S);
    localparam int unsigned RETRY_CYC  = RETRY_MS * (CLK_HZ / MS_PER_S);
    localparam int unsigned SOFT_CYC   = SOFT_START_US * (CLK_HZ / US_PER_S);
    // Dimming levels
    localparam int unsigned LEVEL_W    = 4;
    localparam logic [3:0]  LEVEL_FULL = 4'h0;
    localparam logic [3:0]  LEVEL_LAST = 4'hA;
    localparam logic [3:0]  LEVEL_ONE  = 4'h1;
    localparam int unsigned PCT_W      = 7;
    localparam logic [6:0]  PCT_FULL   = 7'h64;   // 100
    localparam logic [6:0]  PCT_STEP   = 7'h0A;   // 10
    localparam logic [6:0]  PCT_MIN    = 7'h05;   // 5
    localparam logic [6:0]  PCT_ZERO   = 7'h00;
    // Gain codes on the output
    localparam logic [1:0]  GAIN_1X    = 2'h0;
    localparam logic [1:0]  GAIN_15X   = 2'h1;
    localparam logic [1:0]  GAIN_2X    = 2'h2;
    localparam int unsigned MAIN_SINKS = 4;
    localparam int unsigned SUB_SINKS  = 2;
    localparam int unsigned SINKS      = MAIN_SINKS + SUB_SINKS;
    typedef enum logic [1:0] {LPDPMC_OFF, LPDPMC_SOFT, LPDPMC_ON} lpdpmc_grp_e;
    typedef enum logic [1:0] {LPDPMC_G1, LPDPMC_G15, LPDPMC_G2} lpdpmc_gain_e;
endpackage

/* verilog/lpdpmc_top.sv */
// Top: two dimming groups, shutdown, protections and pump gain sequencing
`timescale 1ns/100ps
// What this block does
// (R01) Stay 1x; sink below threshold gives 1.5x
// (R02) 1x to 2x passes 1 ms at 1.5x
// (R03) At 1.5x, retry 1x every 130 ms
// (R04) At 2x, retry 1.5x every 130 ms
// (R05) One group long-low in 2x: back to 1.5x
// (R06) Main input enables and picks 11 levels
// (R07) First main edge: soft start, then full
// (R08) Main pulses step 10%, last 5%, wrap
// (R09) Sub input enables and picks 11 levels
// (R10) First sub edge: soft start, then full
// (R11) Sub pulses step 10%, last 5%, wrap
// (R12) Long low turns group off, level reset at restart
// (R13) Both long low: whole device shuts down
// (R14) Host: long low then N pulses for level
// (R15) Host: send burst within few milliseconds
// (R16) Output short: short mode, auto recover
// (R17) Sink above pump or supply limit: disabled
// (R18) Open LED: other sinks keep running
// (R19) Over temperature shuts down, auto restart; groups stay off after cooling until a new rising edge
// (R20) Host: first high at least 50 us
// (R21) Host: dimming low 0.5 to 250 us
// (R22) Level index 0..10, wraps, cleared by the first rising edge after long low
module lpdpmc_top #(
    parameter int unsigned SHDN_CYC  = lpdpmc_pkg::SHDN_CYC,
    parameter int unsigned SOFT_CYC  = lpdpmc_pkg::SOFT_CYC,
    parameter int unsigned GAIN_CYC  = lpdpmc_pkg::GAIN_CYC,
    parameter int unsigned RETRY_CYC = lpdpmc_pkg::RETRY_CYC,
    parameter int unsigned SINKS     = lpdpmc_pkg::SINKS
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_main_group_pulse_input,
    input  wire logic              i_sub_group_pulse_input,
    input  wire logic [SINKS-1:0]  i_sink_low,
    input  wire logic              i_dropout,
    input  wire logic              i_pump_below_supply,
    input  wire logic              i_pump_short,
    input  wire logic [SINKS-1:0]  i_sink_over_limit,
    input  wire logic              i_over_temp,
    output logic                   o_active,
    output logic                   o_short_mode,
    output logic [1:0]             o_gain,
    output logic [SINKS-1:0]       o_sink_en,
    output logic [6:0]             o_main_pct,
    output logic [6:0]             o_sub_pct,
    output logic [3:0]             o_main_level,
    output logic [3:0]             o_sub_level
);
    logic                    enable_ok;
    logic                    main_on;
    logic                    sub_on;
    logic                    main_ll;
    logic                    sub_ll;
    logic [3:0]              main_lvl;
    logic [3:0]              sub_lvl;
    logic [6:0]              main_pct;
    logic [6:0]              sub_pct;
    logic                    one_off;
    logic                    one_off_d;
    logic                    need_boost;
    logic [SINKS-1:0]        grp_on;
    logic [31:0]             gcnt;
    lpdpmc_pkg::lpdpmc_gain_e gstate;

    // Over temperature blocks enable; clears by itself when it cools
    assign enable_ok = ~i_over_temp;                                // see (R19)

    lpdpmc_group #(
        .SHDN_CYC (SHDN_CYC),
        .SOFT_CYC (SOFT_CYC)
    ) u_main (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_pulse     (i_main_group_pulse_input),
        .i_enable_ok (enable_ok),
        .o_on        (main_on),
        .o_long_low  (main_ll),
        .o_step      (),
        .o_level     (main_lvl),
        .o_pct       (main_pct)
    );

    lpdpmc_group #(
        .SHDN_CYC (SHDN_CYC),
        .SOFT_CYC (SOFT_CYC)
    ) u_sub (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_pulse     (i_sub_group_pulse_input),
        .i_enable_ok (enable_ok),
        .o_on        (sub_on),
        .o_long_low  (sub_ll),
        .o_step      (),
        .o_level     (sub_lvl),
        .o_pct       (sub_pct)
    );

    // ---------------------------------------------------------------
    // Group outputs and device enable
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_active     <= 1'b0;
            o_main_pct   <= lpdpmc_pkg::PCT_ZERO;
            o_sub_pct    <= lpdpmc_pkg::PCT_ZERO;
            o_main_level <= lpdpmc_pkg::LEVEL_FULL;
            o_sub_level  <= lpdpmc_pkg::LEVEL_FULL;
            o_short_mode <= 1'b0;
        end else begin
            o_active     <= enable_ok && !(main_ll && sub_ll);      // see (R13) see (R19)
            o_main_pct   <= main_pct;                               // see (R06)
            o_sub_pct    <= sub_pct;                                // see (R09)
            o_main_level <= main_lvl;
            o_sub_level  <= sub_lvl;
            o_short_mode <= i_pump_short && enable_ok;              // see (R16)
        end
    end

    // ---------------------------------------------------------------
    // Per-sink enables
    // ---------------------------------------------------------------
    genvar s;
    generate
        for (s = 0; s < SINKS; s++) begin : g_sink
            if (s < lpdpmc_pkg::MAIN_SINKS) begin : g_main
                assign grp_on[s] = main_on;
            end else begin : g_sub
                assign grp_on[s] = sub_on;
            end
            // Each sink drops out alone; the rest keep running
            always_ff @(posedge i_clk_sys or posedge i_rst) begin
                if (i_rst) begin
                    o_sink_en[s] <= 1'b0;
                end else begin
                    o_sink_en[s] <= grp_on[s] && enable_ok
                                    && !i_sink_over_limit[s];       // see (R17) see (R18)
                end
            end
        end
    endgenerate

    // Boost is needed when any sink of a group that is on sags below threshold, even one disabled by its over-limit input
    assign need_boost = |(i_sink_low & grp_on);
    // One group long low while the other stays on; level, held for as long as both hold
    assign one_off = (main_ll && sub_on) || (sub_ll && main_on);

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            one_off_d <= 1'b0;
        end else begin
            one_off_d <= one_off;
        end
    end

    // ---------------------------------------------------------------
    // Pump gain sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            gstate <= lpdpmc_pkg::LPDPMC_G1;
            gcnt   <= '0;
        end else if (!o_active || i_pump_short) begin
            gstate <= lpdpmc_pkg::LPDPMC_G1;
            gcnt   <= '0;
        end else begin
            unique case (gstate)
                lpdpmc_pkg::LPDPMC_G1: begin
                    gcnt <= '0;
                    if (need_boost) begin
                        gstate <= lpdpmc_pkg::LPDPMC_G15;           // see (R01)
                    end
                end
                lpdpmc_pkg::LPDPMC_G15: begin
                    gcnt <= gcnt + 32'h1;
                    if (i_dropout && gcnt >= GAIN_CYC - 1) begin
                        gstate <= lpdpmc_pkg::LPDPMC_G2;            // see (R02)
                        gcnt   <= '0;
                    end else if (i_pump_below_supply && gcnt >= RETRY_CYC - 1) begin
                        gstate <= lpdpmc_pkg::LPDPMC_G1;            // see (R03)
                        gcnt   <= '0;
                    end else if (gcnt >= RETRY_CYC - 1) begin
                        gcnt <= RETRY_CYC - 1;
                    end
                end
                lpdpmc_pkg::LPDPMC_G2: begin
                    gcnt <= gcnt + 32'h1;
                    if ((one_off && !one_off_d) || gcnt >= RETRY_CYC - 1) begin
                        gstate <= lpdpmc_pkg::LPDPMC_G15;           // see (R04) see (R05)
                        gcnt   <= '0;
                    end
                end
                default: begin
                    gstate <= lpdpmc_pkg::LPDPMC_G1;
                    gcnt   <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_gain <= lpdpmc_pkg::GAIN_1X;
        end else begin
            unique case (gstate)
                lpdpmc_pkg::LPDPMC_G15: o_gain <= lpdpmc_pkg::GAIN_15X;
                lpdpmc_pkg::LPDPMC_G2:  o_gain <= lpdpmc_pkg::GAIN_2X;
                default:                o_gain <= lpdpmc_pkg::GAIN_1X;
            endcase
        end
    end
endmodule
